// file: sim/rdc_demod_config_bench.sv
// Self-checking bench of the receive demodulator configuration registers.
`timescale 1ns/10ps
module rdc_demod_config_bench
    import rdc_pkg::*;
;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wd;
        logic [31:0] rx;
    } rdc_row_s;

    logic        mclk;
    logic        reset;
    logic        auto_mode_detect_en;
    logic        rx_path_reset;
    logic        short_eval_window;
    logic        trig;
    logic [1:0]  trig_code;
    logic        mode_detected;
    logic [1:0]  mode_det_framing;
    logic [2:0]  arc_sub_offset;
    logic [2:0]  arc_phase_offset;
    rdc_bus_s    bus;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [31:0] w;
    rdc_cfg_s    cfg;
    int          miscompares;
    int          tests_run;
    logic [5:0]  taps [8] = '{6'd4, 6'd6, 6'd8, 6'd8, 6'd16, 6'd18, 6'd24, 6'd32};
    // Reserved bits are set in some rows so that their read-back as zero is seen.
    rdc_row_s    rows [16] = '{
        '{8'h1b, 32'h80000001, 32'h00000001}, '{8'h1b, 32'h24000fff, 32'h24000fff},
        '{8'h1b, 32'h08002000, 32'h08002000}, '{8'h1b, 32'h2c000000, 32'h2c000000},
        '{8'h1b, 32'h13ffffff, 32'h13ffffff}, '{8'h1b, 32'h34000000, 32'h34000000},
        '{8'h1b, 32'h18000000, 32'h18000000}, '{8'h1b, 32'hfc000000, 32'h7c000000},
        '{8'h1c, 32'hff0000fe, 32'h00000000}, '{8'h1c, 32'h00200001, 32'h00200001},
        '{8'h1c, 32'h00420001, 32'h00420001}, '{8'h1c, 32'h00610001, 32'h00610001},
        '{8'h1c, 32'h00880001, 32'h00880001}, '{8'h1c, 32'h00a0fa01, 32'h00a0fa01},
        '{8'h1c, 32'h00c40000, 32'h00c40000}, '{8'h1c, 32'h00e20000, 32'h00e20000}};

    rdc_demod_config u_rdc_demod_config (.mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
        .auto_mode_detect_en(auto_mode_detect_en), .mode_detected(mode_detected),
        .mode_det_framing(mode_det_framing), .rx_path_reset(rx_path_reset),
        .short_eval_window(short_eval_window), .arc_sub_offset(arc_sub_offset),
        .arc_phase_offset(arc_phase_offset), .cfg(cfg));
    rdc_det_model u_rdc_det_model (.mclk(mclk), .reset(reset), .trig(trig), .trig_code(trig_code),
        .mode_detected(mode_detected), .mode_det_framing(mode_det_framing));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    // Offsets are applied after the write so the stored level and the adjusted level can differ.
    task automatic off_case(input logic [31:0] v, input logic [2:0] so, input logic [2:0] po, input logic [7:0] e);
        wr(RDC_RM_OFS, v);
        arc_sub_offset   <= so;
        arc_phase_offset <= po;
        repeat (2) @(posedge mclk);
        #1;
        chk(32'({cfg.subcarrier_min_eff, cfg.phase_min_eff}), 32'(e), "adjusted levels");
        rd(RDC_RM_OFS);
        chk(32'(d[15:8]), 32'(v[15:8]), "stored levels");
        chk(32'(d[7]), 32'(short_eval_window), "short eval");
        arc_sub_offset   <= 3'h0;
        arc_phase_offset <= 3'h0;
    endtask : off_case

    task automatic end_of_test;
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        end_of_test;
    end

    initial begin
        reset               = 1'b1;
        bus                 = '0;
        auto_mode_detect_en = 1'b0;
        rx_path_reset       = 1'b0;
        short_eval_window   = 1'b0;
        trig                = 1'b0;
        trig_code           = 2'h0;
        arc_sub_offset      = 3'h0;
        arc_phase_offset    = 3'h0;
        miscompares         = 0;
        tests_run           = 0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(RDC_CM_OFS);
        chk(d, 32'h0, "card reset value");
        rd(RDC_RM_OFS);
        chk(d, 32'h00080000, "reader reset value");
        chk(32'(cfg.edge_filter_taps), 32'd4, "reset taps");
        for (int i = 0; i < 16; i++) begin
            w = rows[i].wd;
            wr(rows[i].addr, w);
            if (rows[i].addr == RDC_CM_OFS) begin
                chk(32'(cfg.card_framing), 32'(w[30:29]), "framing");
                chk(32'(cfg.edge_filter_taps), 32'(taps[w[28:26]]), "taps");
                chk(32'(cfg.edge_decision_threshold), 32'(w[25:13]), "edge threshold");
                chk(32'(cfg.bit_decision_threshold), 32'(w[12:0]), "bit threshold");
            end else begin
                chk(32'(cfg.iq_channel_select), 32'(w[23:21]), "iq select");
                chk(32'(cfg.iq_select_valid), 32'(!(w[23:21] inside {3'd3, 3'd6, 3'd7})), "iq valid");
                chk(32'(cfg.sof_equal_resync_en), 32'(w[19]), "resync");
                chk(32'(cfg.pattern_filter_on), 32'(w[0] & ~w[17]), "pattern filter");
                chk(32'(cfg.early_data_capture), 32'(w[16]), "early capture");
                chk(32'({cfg.subcarrier_min_eff, cfg.phase_min_eff}), 32'(w[15:8]), "levels");
                chk(32'({cfg.psk_mode, cfg.phase_det_en}), 32'({2{w[0]}}), "psk mode");
            end
            rd(rows[i].addr);
            chk(d, rows[i].rx, "read back");
        end
        // The detector report lands on the same edge as a software write and must win.
        auto_mode_detect_en <= 1'b1;
        @(posedge mclk);
        trig      <= 1'b1;
        trig_code <= 2'h1;
        @(posedge mclk);
        trig <= 1'b0;
        bus  <= '{RDC_CM_OFS, 32'h08000000, 1'b1, 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
        #1;
        chk(32'(cfg.card_framing), 32'h1, "detector wins");
        chk(32'(cfg.edge_filter_taps), 32'd8, "same edge write");
        auto_mode_detect_en <= 1'b0;
        @(posedge mclk);
        trig      <= 1'b1;
        trig_code <= 2'h0;
        @(posedge mclk);
        trig <= 1'b0;
        rd(RDC_CM_OFS);
        chk(d, 32'h28000000, "detector disabled");
        for (int e = 1; e >= 0; e--) begin
            wr(RDC_RM_OFS, 32'(e) << 18);
            @(posedge mclk);
            rx_path_reset <= 1'b1;
            @(posedge mclk);
            rx_path_reset <= 1'b0;
            #1;
            chk(32'(cfg.correlator_clear), 32'(e), "correlator clear");
            @(posedge mclk);
            #1;
            chk(32'(cfg.correlator_clear), 32'h0, "clear is one pulse");
        end
        off_case(32'h00002e01, 3'b111, 3'b011, 8'h0f);
        short_eval_window <= 1'b1;
        off_case(32'h00005301, 3'b010, 3'b101, 8'h72);
        off_case(32'h00003501, 3'b101, 3'b011, 8'h28);
        wr(8'h1a, 32'hffffffff);
        wr(8'h1d, 32'hffffffff);
        rd(RDC_CM_OFS);
        chk(d, 32'h28000000, "unmapped writes ignored");
        rd(8'h1d);
        chk(d, 32'h0, "unmapped read");
        rd(RDC_CM_OFS);
        @(posedge mclk);
        #1;
        chk(rdata, 32'h0, "read data lasts one cycle");
        reset <= 1'b1;
        @(posedge mclk);
        reset <= 1'b0;
        rd(RDC_CM_OFS);
        chk(d, 32'h0, "second reset");
        chk(32'({cfg.sof_equal_resync_en, cfg.iq_select_valid}), 32'h3, "second reset flags");
        end_of_test;
    end
endmodule : rdc_demod_config_bench

// file: sim/rdc_det_model.sv
// Behavioural mode detector on the far side of the framing inputs.
`timescale 1ns/10ps
module rdc_det_model
    import rdc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       trig,
    input  wire logic [1:0] trig_code,
    output logic            mode_detected,
    output logic [1:0]      mode_det_framing
);
    // Between reports the code lines toggle, so sampling them without the flag shows up.
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_detected    <= 1'b0;
            mode_det_framing <= 2'h0;
        end else begin
            mode_detected    <= trig;
            mode_det_framing <= trig ? trig_code : ~mode_det_framing;
        end
    end
endmodule : rdc_det_model

// file: verilog/rdc_demod_config.sv
// Receive demodulator configuration registers with decoded settings for the demodulators.
`timescale 1ns/10ps
// What this block does
// RULE1: Card-mode framing 00b selects type A framing, 01b framing with sync byte F0.
// RULE2: With auto detection on, a detected mode writes the card-mode framing field.
// RULE3: Edge filter tap code maps to 4,6,8,8,16,18,24,32 taps.
// RULE4: Thirteen-bit edge decision threshold drives the card-mode edge decision stage.
// RULE5: Thirteen-bit bit decision threshold drives the card-mode bit decision stage.
// RULE6: I/Q select picks both, I, Q, strongest or first channel; others reserved.
// RULE7: Resync enable, default on, allows resync on equal correlation inside start of frame.
// RULE8: Correlator reset enable clears the correlator whenever the receive path resets.
// RULE9: Pattern filter on unless disabled in phase-shift mode; disabled uses 0110 alone.
// RULE10: Early capture enable, default off, accepts data before first correlation minimum.
// RULE11: Subcarrier minimum level sets subcarrier detector threshold in both schemes.
// RULE12: Lookup adjusts subcarrier minimum by sign-magnitude offset up to three.
// RULE13: Phase minimum level sets phase-shift detector threshold, phase-shift only.
// RULE14: Lookup adjusts phase minimum by up to three steps, top bit is sign.
// RULE15: Read-only short evaluation flag reports correlator evaluation length for Manchester.
// RULE16: Software keeps the test-only filter bit at zero.
// RULE17: Software sets subcarrier minimum above the noise level.
// RULE18: Demodulation select bit at one selects phase-shift demodulation.
// RULE19: Reserved bits read zero; writable fields read back last written or detected value.
module rdc_demod_config
    import rdc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire rdc_bus_s   bus,
    output logic [31:0]     rdata,
    input  wire logic       auto_mode_detect_en,
    input  wire logic       mode_detected,
    input  wire logic [1:0] mode_det_framing,
    input  wire logic       rx_path_reset,
    input  wire logic       short_eval_window,
    input  wire logic [2:0] arc_sub_offset,
    input  wire logic [2:0] arc_phase_offset,
    output rdc_cfg_s        cfg
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  framing;
        logic [2:0]  tap_sel;
        logic [12:0] edge_th;
        logic [12:0] bit_th;
        logic [2:0]  iq;
        logic        test_filt;
        logic        resync;
        logic        corr_rst;
        logic        pat_off;
        logic        early;
        logic [3:0]  sub_min;
        logic [3:0]  ph_min;
        logic        psk;
        logic [31:0] rdata;
        rdc_cfg_s    cfg;
    } rdc_state_s;

    rdc_state_s st_r;
    rdc_state_s st_nxt;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [5:0] rdc_taps(input logic [2:0] sel);
        case (sel)
            3'h0:    rdc_taps = 6'h04;
            3'h1:    rdc_taps = 6'h06;
            3'h2:    rdc_taps = 6'h08;
            3'h3:    rdc_taps = 6'h08;
            3'h4:    rdc_taps = 6'h10;
            3'h5:    rdc_taps = 6'h12;
            3'h6:    rdc_taps = 6'h18;
            default: rdc_taps = 6'h20;
        endcase
    endfunction : rdc_taps

    // Sign-magnitude offset; the sum saturates so a lookup step never wraps the threshold.
    function automatic logic [3:0] rdc_adjust(input logic [3:0] base, input logic [2:0] off);
        logic [4:0] sum;
        sum = {1'b0, base} + {3'h0, off[1:0]};
        if (off[2]) begin
            rdc_adjust = (base < {2'h0, off[1:0]}) ? 4'h0 : base - {2'h0, off[1:0]};
        end else begin
            rdc_adjust = sum[4] ? 4'hf : sum[3:0];
        end
    endfunction : rdc_adjust

    function automatic logic [31:0] rdc_read_cm(input rdc_state_s s);
        rdc_read_cm = {1'b0, s.framing, s.tap_sel, s.edge_th, s.bit_th};
    endfunction : rdc_read_cm

    function automatic logic [31:0] rdc_read_rm(input rdc_state_s s, input logic eval);
        rdc_read_rm = {8'h00, s.iq, s.test_filt, s.resync, s.corr_rst, s.pat_off, s.early,
                       s.sub_min, s.ph_min, eval, 6'h00, s.psk};
    endfunction : rdc_read_rm

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = 32'h0000_0000;
        if (bus.wr && bus.addr == RDC_CM_OFS) begin
            st_nxt.framing = bus.wdata[RDC_CM_FRAMING_LSB +: 2];
            st_nxt.tap_sel = bus.wdata[RDC_CM_TAP_LSB +: 3];
            st_nxt.edge_th = bus.wdata[RDC_CM_EDGE_LSB +: 13];
            st_nxt.bit_th  = bus.wdata[RDC_CM_BIT_LSB +: 13];
        end
        if (bus.wr && bus.addr == RDC_RM_OFS) begin
            st_nxt.iq        = bus.wdata[RDC_RM_IQ_LSB +: 3];
            st_nxt.test_filt = bus.wdata[RDC_RM_TEST_BIT];
            st_nxt.resync    = bus.wdata[RDC_RM_RESYNC_BIT];
            st_nxt.corr_rst  = bus.wdata[RDC_RM_CORR_BIT];
            st_nxt.pat_off   = bus.wdata[RDC_RM_PAT_BIT];
            st_nxt.early     = bus.wdata[RDC_RM_EARLY_BIT];
            st_nxt.sub_min   = bus.wdata[RDC_RM_SUB_LSB +: 4];
            st_nxt.ph_min    = bus.wdata[RDC_RM_PH_LSB +: 4];
            st_nxt.psk       = bus.wdata[RDC_RM_PSK_BIT];
        end
        // The detector result wins over a software write in the same cycle.
        if (auto_mode_detect_en && mode_detected) begin
            st_nxt.framing = mode_det_framing; // RULE2
        end
        if (bus.rd && bus.addr == RDC_CM_OFS) begin
            st_nxt.rdata = rdc_read_cm(st_r); // RULE19
        end else if (bus.rd && bus.addr == RDC_RM_OFS) begin
            st_nxt.rdata = rdc_read_rm(st_r, short_eval_window); // RULE15
        end
        st_nxt.cfg.card_framing            = st_nxt.framing; // RULE1
        st_nxt.cfg.edge_filter_taps        = rdc_taps(st_nxt.tap_sel); // RULE3
        st_nxt.cfg.edge_decision_threshold = st_nxt.edge_th; // RULE4
        st_nxt.cfg.bit_decision_threshold  = st_nxt.bit_th; // RULE5
        st_nxt.cfg.psk_mode                = st_nxt.psk; // RULE18
        st_nxt.cfg.iq_channel_select       = st_nxt.iq;
        st_nxt.cfg.iq_select_valid         = (st_nxt.iq != 3'h3) && (!st_nxt.iq[2] || st_nxt.iq[1:0] < 2'h2); // RULE6
        st_nxt.cfg.sof_equal_resync_en     = st_nxt.resync; // RULE7
        st_nxt.cfg.correlator_clear        = rx_path_reset && st_r.corr_rst; // RULE8
        st_nxt.cfg.pattern_filter_on       = st_nxt.psk && !st_nxt.pat_off; // RULE9
        st_nxt.cfg.early_data_capture      = st_nxt.early; // RULE10
        st_nxt.cfg.subcarrier_min_eff      = rdc_adjust(st_nxt.sub_min, arc_sub_offset); // RULE11 RULE12
        st_nxt.cfg.phase_min_eff           = rdc_adjust(st_nxt.ph_min, arc_phase_offset); // RULE14
        st_nxt.cfg.phase_det_en            = st_nxt.psk; // RULE13
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r           <= '0;
            st_r.framing   <= RDC_FRAMING_RST;
            st_r.tap_sel   <= RDC_TAP_RST;
            st_r.edge_th   <= RDC_TH_RST;
            st_r.bit_th    <= RDC_TH_RST;
            st_r.iq        <= RDC_IQ_RST;
            st_r.test_filt <= RDC_BIT_RST;
            st_r.resync    <= RDC_RESYNC_RST;
            st_r.corr_rst  <= RDC_BIT_RST;
            st_r.pat_off   <= RDC_BIT_RST;
            st_r.early     <= RDC_BIT_RST;
            st_r.sub_min   <= RDC_LEVEL_RST;
            st_r.ph_min    <= RDC_LEVEL_RST;
            st_r.psk       <= RDC_BIT_RST;
            st_r.cfg.edge_filter_taps    <= 6'h04;
            st_r.cfg.iq_select_valid     <= 1'b1;
            st_r.cfg.sof_equal_resync_en <= RDC_RESYNC_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign cfg   = st_r.cfg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    wire cm_wr = bus.wr && bus.addr == RDC_CM_OFS;
    wire rm_wr = bus.wr && bus.addr == RDC_RM_OFS;
    wire det   = auto_mode_detect_en && mode_detected;

    property p_framing_write;
        cm_wr && !det |=> cfg.card_framing == $past(bus.wdata[30:29]);
    endproperty
    a_framing_write: assert property (p_framing_write) else $error("framing not stored"); // RULE1

    property p_framing_detect;
        det |=> cfg.card_framing == $past(mode_det_framing);
    endproperty
    a_framing_detect: assert property (p_framing_detect) else $error("detector framing lost"); // RULE2

    property p_taps;
        cm_wr && bus.wdata[28:26] == 3'h5 |=> cfg.edge_filter_taps == 6'h12;
    endproperty
    a_taps: assert property (p_taps) else $error("tap count wrong"); // RULE3

    property p_thresholds;
        cm_wr |=> cfg.edge_decision_threshold == $past(bus.wdata[25:13]) &&
                  cfg.bit_decision_threshold == $past(bus.wdata[12:0]);
    endproperty
    a_thresholds: assert property (p_thresholds) else $error("threshold not stored"); // RULE4 RULE5

    property p_iq_reserved;
        rm_wr && bus.wdata[23:21] == 3'h3 |=> !cfg.iq_select_valid;
    endproperty
    a_iq_reserved: assert property (p_iq_reserved) else $error("reserved iq code accepted"); // RULE6

    sequence s_rx_reset_armed;
        rx_path_reset && st_r.corr_rst;
    endsequence
    property p_corr_clear;
        s_rx_reset_armed |=> cfg.correlator_clear ##1 (cfg.correlator_clear == $past(rx_path_reset && st_r.corr_rst));
    endproperty
    a_corr_clear: assert property (p_corr_clear) else $error("correlator not cleared"); // RULE8

    property p_pattern;
        rm_wr |=> cfg.pattern_filter_on == ($past(bus.wdata[0]) && !$past(bus.wdata[17]));
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern filter mode wrong"); // RULE9

    property p_sub_down;
        !rm_wr && arc_sub_offset == 3'h5 && st_r.sub_min != 4'h0
            |=> cfg.subcarrier_min_eff == $past(st_r.sub_min) - 4'h1;
    endproperty
    a_sub_down: assert property (p_sub_down) else $error("subcarrier offset wrong"); // RULE12

    property p_phase_up;
        !rm_wr && arc_phase_offset == 3'h3 && st_r.ph_min < 4'hd |=> cfg.phase_min_eff == $past(st_r.ph_min) + 4'h3;
    endproperty
    a_phase_up: assert property (p_phase_up) else $error("phase offset wrong"); // RULE14

    property p_rm_read;
        bus.rd && bus.addr == RDC_RM_OFS |=> rdata[31:24] == 8'h00 && rdata[7] == $past(short_eval_window)
                                           && rdata[6:1] == 6'h00
                                           && rdata[15:8] == {$past(st_r.sub_min), $past(st_r.ph_min)};
    endproperty
    a_rm_read: assert property (p_rm_read) else $error("reader register read wrong"); // RULE15 RULE19

    property p_unmapped;
        bus.rd && bus.addr != RDC_CM_OFS && bus.addr != RDC_RM_OFS |=> rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // RULE19

endmodule : rdc_demod_config

// file: verilog/rdc_pkg.sv
// Constants, field layouts and carrier types of the receive demodulator configuration block.
package rdc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int         RDC_AW         = 8;
    localparam logic [7:0] RDC_CM_OFS     = 8'h1b;
    localparam logic [7:0] RDC_RM_OFS     = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RDC_CM_FRAMING_LSB = 29;
    localparam int RDC_CM_TAP_LSB     = 26;
    localparam int RDC_CM_EDGE_LSB    = 13;
    localparam int RDC_CM_BIT_LSB     = 0;
    localparam int RDC_RM_IQ_LSB      = 21;
    localparam int RDC_RM_TEST_BIT    = 20;
    localparam int RDC_RM_RESYNC_BIT  = 19;
    localparam int RDC_RM_CORR_BIT    = 18;
    localparam int RDC_RM_PAT_BIT     = 17;
    localparam int RDC_RM_EARLY_BIT   = 16;
    localparam int RDC_RM_SUB_LSB     = 12;
    localparam int RDC_RM_PH_LSB      = 8;
    localparam int RDC_RM_EVAL_BIT    = 7;
    localparam int RDC_RM_PSK_BIT     = 0;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [1:0]  RDC_FRAMING_RST = 2'h0;
    localparam logic [2:0]  RDC_TAP_RST     = 3'h0;
    localparam logic [12:0] RDC_TH_RST      = 13'h0000;
    localparam logic [2:0]  RDC_IQ_RST      = 3'h0;
    localparam logic        RDC_RESYNC_RST  = 1'b1;
    localparam logic        RDC_BIT_RST     = 1'b0;
    localparam logic [3:0]  RDC_LEVEL_RST   = 4'h0;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RDC_FRAME_TYPE_A  = 2'b00,
        RDC_FRAME_SYNC_F0 = 2'b01
    } rdc_framing_e;

    typedef enum logic [2:0] {
        RDC_IQ_BOTH      = 3'b000,
        RDC_IQ_I_ONLY    = 3'b001,
        RDC_IQ_Q_ONLY    = 3'b010,
        RDC_IQ_STRONGEST = 3'b100,
        RDC_IQ_FIRST     = 3'b101
    } rdc_iq_e;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [RDC_AW-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } rdc_bus_s;

    typedef struct packed {
        logic [1:0]  card_framing;
        logic [5:0]  edge_filter_taps;
        logic [12:0] edge_decision_threshold;
        logic [12:0] bit_decision_threshold;
        logic        psk_mode;
        logic [2:0]  iq_channel_select;
        logic        iq_select_valid;
        logic        sof_equal_resync_en;
        logic        correlator_clear;
        logic        pattern_filter_on;
        logic        early_data_capture;
        logic [3:0]  subcarrier_min_eff;
        logic [3:0]  phase_min_eff;
        logic        phase_det_en;
    } rdc_cfg_s;

endpackage : rdc_pkg
